// file: rtl/tcm_bucket.sv
// Two-bucket marking decision for one lookup: leak, refill and color
`timescale 1ns/1ps
`default_nettype none
module tcm_bucket (
  // Entry settings
  input wire tcm_pkg::tcm_mode_type mode,
  input wire logic aware,
  input wire logic [tcm_pkg::TCM_RATE_W-1:0] rate0,
  input wire logic [tcm_pkg::TCM_RATE_W-1:0] rate1,
  input wire logic [tcm_pkg::TCM_BURST_W-1:0] burst0,
  input wire logic [tcm_pkg::TCM_BURST_W-1:0] burst1,
  // Bucket state
  input wire logic [tcm_pkg::TCM_TOKEN_W-1:0] fill0,
  input wire logic [tcm_pkg::TCM_TOKEN_W-1:0] fill1,
  input wire logic [15:0] ticks,
  // Packet
  input wire logic charge_en,
  input wire logic [15:0] cost,
  input wire tcm_pkg::tcm_color_type color_in,
  // Result
  output logic [tcm_pkg::TCM_TOKEN_W-1:0] fill0_new,
  output logic [tcm_pkg::TCM_TOKEN_W-1:0] fill1_new,
  output tcm_pkg::tcm_color_type color_out
);
  import tcm_pkg::*;

  localparam int LW = TCM_TOKEN_W + 20;
  localparam logic [LW-1:0] SAT = LW'({TCM_TOKEN_W{1'b1}});

  logic [LW-1:0] l0;
  logic [LW-1:0] l1;
  logic [LW-1:0] a0;
  logic [LW-1:0] a1;
  logic [LW-1:0] s0;
  logic [LW-1:0] s1;
  logic [LW-1:0] d0;
  logic [LW-1:0] d1;
  logic [LW-1:0] lk;

  // Leak, add packet tokens and choose the color
  always_comb begin
    d0 = LW'(rate0) * LW'(ticks);
    d1 = LW'(rate1) * LW'(ticks);
    s0 = LW'(fill0);
    s1 = LW'(fill1);
    l0 = s0;
    l1 = s1;
    lk = '0;
    a0 = '0;
    a1 = '0;
    color_out = TCM_GREEN;
    unique case (mode)
      TCM_MODE_SINGLE: begin
        // Committed rate drains bucket 0, spill-over drains bucket 1
        l0 = (s0 > d0) ? s0 - d0 : '0;
        lk = (s0 > d0) ? '0 : d0 - s0;
        l1 = (s1 > lk) ? s1 - lk : '0;
      end
      TCM_MODE_OFF: begin
        l0 = s0;
        l1 = s1;
      end
      default: begin
        // Both buckets drain together at their own rates
        l0 = (s0 > d0) ? s0 - d0 : '0;
        l1 = (s1 > d1) ? s1 - d1 : '0;
      end
    endcase
    if (charge_en) begin
      unique case (mode)
        TCM_MODE_DUAL: begin
          // Every packet charges both buckets
          a0 = l0 + LW'(cost);
          a1 = l1 + LW'(cost);
          if (a0 > LW'(burst0) || a1 > LW'(burst1)) begin
            color_out = TCM_RED;
          end else begin
            color_out = TCM_GREEN;
          end
        end
        TCM_MODE_SINGLE, TCM_MODE_TWO: begin
          // Aware entries never promote an incoming color
          a0 = l0 + LW'(cost);
          a1 = l1 + LW'(cost);
          if (aware && color_in == TCM_RED) begin
            color_out = TCM_RED;
            a0 = l0;
            a1 = l1;
          end else if (a0 <= LW'(burst0) && !(aware && color_in == TCM_YELLOW)) begin
            color_out = TCM_GREEN;
            a1 = l1;
          end else if (a1 <= LW'(burst1)) begin
            color_out = TCM_YELLOW;
            a0 = l0;
          end else begin
            color_out = TCM_RED;
            a0 = l0;
            a1 = l1;
          end
        end
        default: begin
          a0 = l0;
          a1 = l1;
        end
      endcase
    end else begin
      a0 = l0;
      a1 = l1;
    end
    fill0_new = (a0 > SAT) ? TCM_TOKEN_W'(SAT) : TCM_TOKEN_W'(a0);
    fill1_new = (a1 > SAT) ? TCM_TOKEN_W'(SAT) : TCM_TOKEN_W'(a1);
  end
endmodule
`default_nettype wire

// file: rtl/tcm_meter.sv
// Three-color meter: entry table, lookup pipe, exceed flags and APB slave
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Byte counting adds preamble and gap when the global overhead bit is 1.
// - Dual-bucket mode charges both buckets and drains both at own rates.
// - Dual-bucket mode marks red when either bucket passes its burst.
// - Single-rate mode drains bucket 0, and bucket 1 only once bucket 0 is empty.
// - Single-rate: green within CBS, yellow into bucket 1, red past EBS.
// - Color-aware entries in single- and two-rate mode respect the incoming color, blind and dual-bucket ones ignore it.
// - Two-rate mode drains bucket 0 at CIR and bucket 1 at PIR together.
// - Two-rate: green within CBS, yellow into bucket 1, red past PBS.
// - Each entry has an exceed flag, 32 flags to a status word.
// - Group bits OR the flags of 16 consecutive entries.
// - Type field: 0 off, 1 dual, 2 single rate, 3 two rate.
// - Counting bit 0 bytes, 1 packets; aware bit 0 blind, 1 aware.
// - Writing the clear control empties that entry's buckets.
// - 16 blocks of 32 entries, each with its own rates and bursts.
module tcm_meter #(
  parameter int ENTRIES = tcm_pkg::TCM_BLOCKS * tcm_pkg::TCM_PER_BLOCK,
  parameter int TICK_CYCLES = tcm_pkg::TCM_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Lookup request
  input wire logic req_valid,
  input wire logic [8:0] req_entry,
  input wire logic [15:0] req_len,
  input wire tcm_pkg::tcm_color_type req_color,
  // Lookup answer
  output logic res_valid,
  output tcm_pkg::tcm_color_type res_color
);
  import tcm_pkg::*;

  localparam int GROUPS = ENTRIES / TCM_GROUP_SIZE;
  localparam int WORDS = ENTRIES / 32;

  initial begin
    if (ENTRIES < 32 || ENTRIES > 512 || (ENTRIES % 32) != 0) begin
      $error("entry count must be a multiple of 32 up to 512");
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [TCM_ENTRY_W-1:0] cfg_mem [ENTRIES];
  logic [TCM_TOKEN_W-1:0] fill0_mem [ENTRIES];
  logic [TCM_TOKEN_W-1:0] fill1_mem [ENTRIES];
  logic [15:0] stamp_mem [ENTRIES];
  logic [ENTRIES-1:0] over_reg;
  logic [ENTRIES-1:0] over_next;
  logic [ENTRIES-1:0] clr_mask;
  logic [ENTRIES-1:0] set_mask;
  logic [ENTRIES-1:0] zero_mask;
  logic incl_reg;
  logic incl_next;
  logic [8:0] sel_reg;
  logic [8:0] sel_next;
  logic [3:0] oidx_reg;
  logic [3:0] oidx_next;
  logic [31:0] hold0_reg;
  logic [31:0] hold0_next;
  logic [31:0] hold1_reg;
  logic [31:0] hold1_next;
  logic [31:0] prdata_next;
  logic [15:0] now_reg;
  logic tick;
  logic [31:0] group_word;
  logic [GROUPS-1:0] group_flags;
  logic wr_en;
  logic rd_en;
  logic cfg_wr;
  logic [TCM_ENTRY_W-1:0] cfg_wdata;

  // Pipeline stage registers
  logic p_valid_reg;
  logic [8:0] p_entry_reg;
  logic [15:0] p_len_reg;
  tcm_color_type p_color_reg;
  logic res_valid_next;
  tcm_color_type res_color_reg;
  tcm_color_type res_color_next;

  // ----------------------------------------------------------------
  // Refill time base
  // ----------------------------------------------------------------
  tcm_tick #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick)
  );

  // Free running tick count, each entry remembers when it last leaked
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      now_reg <= 16'h0000;
    end else if (tick) begin
      now_reg <= now_reg + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Lookup: entry read, bucket update, color
  // ----------------------------------------------------------------
  logic [TCM_ENTRY_W-1:0] cur_cfg;
  logic [15:0] cost;
  logic [15:0] elapsed;
  logic [TCM_TOKEN_W-1:0] f0_new;
  logic [TCM_TOKEN_W-1:0] f1_new;
  tcm_color_type col;
  tcm_mode_type cur_mode;

  assign cur_cfg = cfg_mem[p_entry_reg];
  assign cur_mode = tcm_mode_type'(cur_cfg[TCM_TYPE_HI:TCM_TYPE_LO]);
  assign elapsed = now_reg - stamp_mem[p_entry_reg];

  // Packet cost, optional line overhead
  always_comb begin
    if (cur_cfg[TCM_COUNT_BIT]) begin
      cost = 16'h0001;
    end else if (incl_reg) begin
      cost = p_len_reg + TCM_OVERHEAD_BYTES;
    end else begin
      cost = p_len_reg;
    end
  end

  tcm_bucket u_bucket (
    .mode(cur_mode),
    .aware(cur_cfg[TCM_AWARE_BIT]),
    .rate0(cur_cfg[TCM_RATE0_HI:TCM_RATE0_LO]),
    .rate1(cur_cfg[TCM_RATE1_HI:TCM_RATE1_LO]),
    .burst0(cur_cfg[TCM_BURST0_HI:TCM_BURST0_LO]),
    .burst1(cur_cfg[TCM_BURST1_HI:TCM_BURST1_LO]),
    .fill0(fill0_mem[p_entry_reg]),
    .fill1(fill1_mem[p_entry_reg]),
    .ticks(elapsed),
    .charge_en(p_valid_reg),
    .cost(cost),
    .color_in(p_color_reg),
    .fill0_new(f0_new),
    .fill1_new(f1_new),
    .color_out(col)
  );

  // Answer next values; a disabled entry passes the arriving color
  always_comb begin
    res_valid_next = p_valid_reg;
    res_color_next = res_color_reg;
    if (p_valid_reg) begin
      if (cur_mode == TCM_MODE_OFF) begin
        res_color_next = p_color_reg;
      end else begin
        res_color_next = col;
      end
    end
  end

  // Lookup stage and answer registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      p_valid_reg <= 1'b0;
      p_entry_reg <= 9'h000;
      p_len_reg <= 16'h0000;
      p_color_reg <= TCM_GREEN;
      res_valid <= 1'b0;
      res_color_reg <= TCM_GREEN;
    end else begin
      p_valid_reg <= req_valid && (32'(req_entry) < ENTRIES);
      p_entry_reg <= req_entry;
      p_len_reg <= req_len;
      p_color_reg <= req_color;
      res_valid <= res_valid_next;
      res_color_reg <= res_color_next;
    end
  end
  assign res_color = res_color_reg;

  // Bucket memory: charge on lookup, zeroed by the clear control
  always_ff @(posedge clk) begin
    if (cfg_wr && cfg_wdata[TCM_CLEAR_BIT]) begin
      fill0_mem[sel_reg] <= '0;
      fill1_mem[sel_reg] <= '0;
      stamp_mem[sel_reg] <= now_reg;
    end else if (p_valid_reg) begin
      fill0_mem[p_entry_reg] <= f0_new;
      fill1_mem[p_entry_reg] <= f1_new;
      stamp_mem[p_entry_reg] <= now_reg;
    end
  end

  // ----------------------------------------------------------------
  // Exceed flags
  // ----------------------------------------------------------------
  // Set wins over a clear landing in the same cycle
  always_comb begin
    set_mask = '0;
    if (p_valid_reg && cur_mode != TCM_MODE_OFF && col == TCM_RED) begin
      set_mask[p_entry_reg] = 1'b1;
    end
    clr_mask = '0;
    if (wr_en && paddr == TCM_ENTRY_OVER_OFS) begin
      clr_mask[oidx_reg*32 +: 32] = pwdata;
    end
    zero_mask = '0;
    over_next = (over_reg & ~clr_mask) | set_mask;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      over_reg <= zero_mask;
    end else begin
      over_reg <= over_next;
    end
  end

  // Group flags, one per 16 consecutive entries
  genvar g;
  generate
    for (g = 0; g < GROUPS; g++) begin : g_group
      assign group_flags[g] = |over_reg[g*TCM_GROUP_SIZE +: TCM_GROUP_SIZE];
    end
  endgenerate
  assign group_word = 32'(group_flags);

  // ----------------------------------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------------------------------
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign cfg_wr = wr_en && paddr == TCM_ENTRY_CFG2_OFS;
  assign cfg_wdata = {pwdata, hold1_reg, hold0_reg};

  // Entry table write; the staged words go in with the top word
  always_ff @(posedge clk) begin
    if (cfg_wr) begin
      cfg_mem[sel_reg] <= cfg_wdata & ~(TCM_ENTRY_W'(1) << TCM_CLEAR_BIT);
    end
  end

  // Control register next values
  always_comb begin
    incl_next = incl_reg;
    sel_next = sel_reg;
    oidx_next = oidx_reg;
    hold0_next = hold0_reg;
    hold1_next = hold1_reg;
    if (wr_en) begin
      unique case (paddr)
        TCM_GLOBAL_CTRL_OFS: incl_next = pwdata[TCM_OVERHEAD_BIT];
        TCM_ENTRY_SEL_OFS: sel_next = pwdata[8:0];
        TCM_ENTRY_CFG0_OFS: hold0_next = pwdata;
        TCM_ENTRY_CFG1_OFS: hold1_next = pwdata;
        TCM_ENTRY_OVER_IDX_OFS: oidx_next = pwdata[3:0];
        default: incl_next = incl_reg;
      endcase
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    prdata_next = 32'h0000_0000;
    unique case (paddr)
      TCM_GLOBAL_CTRL_OFS: prdata_next = 32'(incl_reg);
      TCM_ENTRY_SEL_OFS: prdata_next = 32'(sel_reg);
      TCM_ENTRY_CFG0_OFS: prdata_next = cfg_mem[sel_reg][31:0];
      TCM_ENTRY_CFG1_OFS: prdata_next = cfg_mem[sel_reg][63:32];
      TCM_ENTRY_CFG2_OFS: prdata_next = cfg_mem[sel_reg][95:64];
      TCM_ENTRY_OVER_IDX_OFS: prdata_next = 32'(oidx_reg);
      TCM_ENTRY_OVER_OFS: prdata_next = over_reg[oidx_reg*32 +: 32];
      TCM_GROUP_OVER_OFS: prdata_next = group_word;
      default: prdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      incl_reg <= TCM_OVERHEAD_RST;
      sel_reg <= 9'h000;
      oidx_reg <= 4'h0;
      hold0_reg <= 32'h0000_0000;
      hold1_reg <= 32'h0000_0000;
    end else begin
      incl_reg <= incl_next;
      sel_reg <= sel_next;
      oidx_reg <= oidx_next;
      hold0_reg <= hold0_next;
      hold1_reg <= hold1_next;
    end
  end

  // Combinational read data so the answer lands in the access cycle
  assign prdata = rd_en ? prdata_next : 32'h0000_0000;
  assign pslverr = 1'b0;
endmodule
`default_nettype wire

// file: rtl/tcm_pkg.sv
// Package for the three-color meter: register map, entry layout, encodings and timing
package tcm_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on APB)
  // ----------------------------------------------------------------
  localparam logic [11:0] TCM_GLOBAL_CTRL_OFS = 12'h000;
  localparam logic [11:0] TCM_ENTRY_SEL_OFS = 12'h004;
  localparam logic [11:0] TCM_ENTRY_CFG0_OFS = 12'h008;
  localparam logic [11:0] TCM_ENTRY_CFG1_OFS = 12'h00C;
  localparam logic [11:0] TCM_ENTRY_CFG2_OFS = 12'h010;
  localparam logic [11:0] TCM_ENTRY_OVER_IDX_OFS = 12'h014;
  localparam logic [11:0] TCM_ENTRY_OVER_OFS = 12'h018;
  localparam logic [11:0] TCM_GROUP_OVER_OFS = 12'h01C;

  // ----------------------------------------------------------------
  // Global control fields and reset values
  // ----------------------------------------------------------------
  localparam int TCM_OVERHEAD_BIT = 0;
  localparam logic TCM_OVERHEAD_RST = 1'b0;
  localparam logic [15:0] TCM_OVERHEAD_BYTES = 16'h0014;

  // ----------------------------------------------------------------
  // Entry layout, 96 bits
  // ----------------------------------------------------------------
  localparam int TCM_ENTRY_W = 96;
  localparam int TCM_TYPE_HI = 95;
  localparam int TCM_TYPE_LO = 94;
  localparam int TCM_COUNT_BIT = 93;
  localparam int TCM_AWARE_BIT = 92;
  localparam int TCM_CLEAR_BIT = 91;
  localparam int TCM_RATE0_HI = 90;
  localparam int TCM_RATE0_LO = 71;
  localparam int TCM_BURST0_HI = 70;
  localparam int TCM_BURST0_LO = 54;
  localparam int TCM_RATE1_HI = 53;
  localparam int TCM_RATE1_LO = 34;
  localparam int TCM_BURST1_HI = 33;
  localparam int TCM_BURST1_LO = 17;
  localparam int TCM_RATE_W = 20;
  localparam int TCM_BURST_W = 17;
  localparam int TCM_TOKEN_W = 18;

  // ----------------------------------------------------------------
  // Geometry and timing
  // ----------------------------------------------------------------
  localparam int TCM_BLOCKS = 16;
  localparam int TCM_PER_BLOCK = 32;
  localparam int TCM_GROUP_SIZE = 16;
  localparam int TCM_CLK_MHZ = 100;
  localparam int TCM_TICK_US = 1;
  localparam int TCM_TICK_CYCLES = TCM_TICK_US * TCM_CLK_MHZ;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TCM_MODE_OFF = 2'h0,
    TCM_MODE_DUAL = 2'h1,
    TCM_MODE_SINGLE = 2'h2,
    TCM_MODE_TWO = 2'h3
  } tcm_mode_type;

  typedef enum logic [1:0] {
    TCM_GREEN = 2'h0,
    TCM_YELLOW = 2'h1,
    TCM_RED = 2'h2
  } tcm_color_type;

endpackage

// file: rtl/tcm_tick.sv
// Refill tick divider for the three-color meter
`timescale 1ns/1ps
`default_nettype none
module tcm_tick #(
  parameter int CYCLES = tcm_pkg::TCM_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Tick out
  output logic tick
);
  import tcm_pkg::*;

  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;

  initial begin
    if (CYCLES < 1 || CYCLES > 65535) begin
      $error("tick period out of range");
    end
  end

  // Count down, pulse at zero
  always_comb begin
    if (cnt_reg == 16'h0000) begin
      cnt_next = 16'(CYCLES - 1);
    end else begin
      cnt_next = cnt_reg - 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign tick = (cnt_reg == 16'h0000);
endmodule
`default_nettype wire

// file: verification/tb_three_color_meter.sv
// Testbench for the meter: table of metering cases, then flag, clear and reset checks
`timescale 1ns/1ps
`default_nettype none
module tb_three_color_meter;
  import tcm_pkg::*;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [31:0] grp = 32'h0;
  logic pready;
  logic pslverr;
  logic req_valid;
  logic res_valid;
  logic [8:0] req_entry;
  logic [15:0] req_len;
  tcm_color_type req_color;
  tcm_color_type res_color;
  int mismatches = 0;
  int cmp_count = 0;

  always #5 clk = ~clk;

  // Short tick keeps drain cases brief
  tcm_meter #(.TICK_CYCLES(4)) dut_u (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .req_valid(req_valid), .req_entry(req_entry),
    .req_len(req_len), .req_color(req_color), .res_valid(res_valid), .res_color(res_color));
  tcm_lkp_src src_u (.clk(clk), .req_valid(req_valid), .req_entry(req_entry),
    .req_len(req_len), .req_color(req_color));

  // ----------------------------------------------------------------
  // Case table: entry setup, three packets and their colors
  // ----------------------------------------------------------------
  localparam tcm_color_type G = TCM_GREEN;
  localparam tcm_color_type Y = TCM_YELLOW;
  localparam tcm_color_type R = TCM_RED;
  typedef struct packed {
    tcm_mode_type mode;
    logic aware;
    logic cnt;
    logic [19:0] rate;
    logic [16:0] b0;
    logic [16:0] b1;
    logic ovh;
    logic [15:0] len;
    tcm_color_type cin;
    logic [7:0] gap;
    tcm_color_type [2:0] exp;
  } tcm_row_type;
  // Rate 0 freezes buckets so colors depend on fills only
  localparam tcm_row_type ROWS [12] = '{
    '{TCM_MODE_DUAL, 0, 1, 0, 2, 9, 0, 64, G, 2, {R, G, G}},
    '{TCM_MODE_DUAL, 0, 1, 0, 9, 1, 0, 64, G, 2, {R, R, G}},
    '{TCM_MODE_SINGLE, 0, 1, 0, 1, 1, 0, 64, G, 2, {R, Y, G}},
    '{TCM_MODE_TWO, 0, 1, 0, 1, 1, 0, 64, G, 2, {R, Y, G}},
    '{TCM_MODE_TWO, 1, 1, 0, 9, 9, 0, 64, R, 2, {R, R, R}},
    '{TCM_MODE_TWO, 0, 1, 0, 9, 9, 0, 64, R, 2, {G, G, G}},
    '{TCM_MODE_SINGLE, 1, 1, 0, 9, 9, 0, 64, Y, 2, {Y, Y, Y}},
    '{TCM_MODE_OFF, 0, 1, 0, 1, 1, 0, 64, Y, 2, {Y, Y, Y}},
    '{TCM_MODE_DUAL, 0, 0, 0, 100, 17'h1FFFF, 0, 50, G, 2, {R, G, G}},
    '{TCM_MODE_DUAL, 0, 0, 0, 100, 17'h1FFFF, 1, 40, G, 2, {R, R, G}},
    '{TCM_MODE_DUAL, 0, 1, 1, 1, 9, 0, 64, G, 40, {G, G, G}},
    '{TCM_MODE_SINGLE, 0, 1, 1, 1, 1, 0, 64, G, 40, {G, G, G}}};

  // ----------------------------------------------------------------
  // Compare tasks and closing report
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_color(input tcm_color_type got, input tcm_color_type exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t color %0d expected %0d", $time, got, exp);
    end
  endtask
  // Bounded waits: an exhausted bound ends the run as a failure
  task automatic timed_out(input logic ok);
    if (!ok) begin
      mismatches++;
      $display("MISMATCH t=%0t no answer", $time);
      summarize();
    end
  endtask

  // APB master: setup, access, hold until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    timed_out(pready === 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One lookup, answer expected with the given color
  task automatic lookup(input logic [8:0] e, input logic [15:0] len, input tcm_color_type c,
                        input tcm_color_type x);
    int n;
    src_u.issue(e, len, c);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (res_valid !== 1'b1 && n < 20);
    timed_out(res_valid === 1'b1);
    check_color(res_color, x);
  endtask

  // Writing the entry always sets the clear control, so buckets start empty
  task automatic run_row(input int i);
    tcm_row_type r;
    logic [95:0] cfg;
    logic [8:0] e;
    logic red;
    r = ROWS[i];
    e = 9'(i * 33);
    red = 1'b0;
    cfg = {r.mode, r.cnt, r.aware, 1'b1, r.rate, r.b0, r.rate, r.b1, 17'h0};
    apb(1'b1, TCM_GLOBAL_CTRL_OFS, {31'h0, r.ovh}, rd);
    apb(1'b1, TCM_ENTRY_SEL_OFS, {23'h0, e}, rd);
    apb(1'b1, TCM_ENTRY_CFG0_OFS, cfg[31:0], rd);
    apb(1'b1, TCM_ENTRY_CFG1_OFS, cfg[63:32], rd);
    apb(1'b1, TCM_ENTRY_CFG2_OFS, cfg[95:64], rd);
    for (int k = 0; k < 3; k++) begin
      lookup(e, r.len, r.cin, r.exp[k]);
      red = red | (r.exp[k] == R);
      repeat (r.gap) @(posedge clk);
    end
    apb(1'b1, TCM_ENTRY_OVER_IDX_OFS, {28'h0, e[8:5]}, rd);
    apb(1'b0, TCM_ENTRY_OVER_OFS, 32'h0, rd);
    check32(rd, {31'h0, red} << e[4:0]);
    grp[e[8:4]] = red;
    $display("Row %0d done", i);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, TCM_GLOBAL_CTRL_OFS, 32'h0, rd);
    check32(rd, 32'h0);
    apb(1'b0, TCM_GROUP_OVER_OFS, 32'h0, rd);
    check32(rd, 32'h0);
    apb(1'b0, 12'h020, 32'h0, rd);
    check32(rd, 32'h0);
    $display("Reset test done");
    for (int i = 0; i < 12; i++) begin
      run_row(i);
    end
    apb(1'b0, TCM_GROUP_OVER_OFS, 32'h0, rd);
    check32(rd, grp);
    // Write one to clear the flag of entry 0, then its group drops too
    apb(1'b1, TCM_ENTRY_OVER_IDX_OFS, 32'h0, rd);
    apb(1'b1, TCM_ENTRY_OVER_OFS, 32'h1, rd);
    apb(1'b0, TCM_ENTRY_OVER_OFS, 32'h0, rd);
    check32(rd, 32'h0);
    grp[0] = 1'b0;
    apb(1'b0, TCM_GROUP_OVER_OFS, 32'h0, rd);
    check32(rd, grp);
    // Rewriting with the clear control restarts from empty buckets
    run_row(0);
    $display("Clear test done");
    // Mid-run reset drops flags, overhead bit and the last red answer
    apb(1'b1, TCM_GLOBAL_CTRL_OFS, 32'h1, rd);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    check_color(res_color, G);
    apb(1'b0, TCM_GROUP_OVER_OFS, 32'h0, rd);
    check32(rd, 32'h0);
    apb(1'b0, TCM_GLOBAL_CTRL_OFS, 32'h0, rd);
    check32(rd, 32'h0);
    $display("Mid-run reset test done");
    summarize();
  end
endmodule
`default_nettype wire

// file: verification/tcm_lkp_src.sv
// Lookup source standing in for the classification pipeline
`timescale 1ns/1ps
`default_nettype none
module tcm_lkp_src import tcm_pkg::*; (
  // Clock
  input wire logic clk,
  // Lookup request
  output logic req_valid,
  output logic [8:0] req_entry,
  output logic [15:0] req_len,
  output tcm_pkg::tcm_color_type req_color
);
  // Quiet request lines from time zero
  initial begin
    req_valid = 1'b0;
    req_entry = 9'h000;
    req_len = 16'h0000;
    req_color = TCM_GREEN;
  end

  // One-cycle pulse; each entry used by this single source only
  task automatic issue(input logic [8:0] e, input logic [15:0] len, input tcm_color_type c);
    @(posedge clk);
    req_valid <= 1'b1;
    req_entry <= e;
    req_len <= len;
    req_color <= c;
    @(posedge clk);
    req_valid <= 1'b0;
    // Scramble released fields so a stale value never looks valid
    req_entry <= ~e;
    req_len <= ~len;
    req_color <= tcm_color_type'(~c);
  endtask
endmodule
`default_nettype wire

// file: verification/tcm_meter_monitor.sv
// Checker for the meter: bus answers, lookup timing and control readback
`timescale 1ns/1ps
`default_nettype none
module tcm_meter_monitor import tcm_pkg::*; #(
  parameter int ENTRIES = 512,
  parameter int TICK_CYCLES = 100
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Lookup
  input wire logic req_valid,
  input wire logic [8:0] req_entry,
  input wire logic [15:0] req_len,
  input wire tcm_pkg::tcm_color_type req_color,
  input wire logic res_valid,
  input wire tcm_pkg::tcm_color_type res_color
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic rd_acc;
  logic ovh_reg;
  logic ovh_next;
  assign rd_acc = psel && penable && !pwrite;

  // Shadow of the overhead bit as software last wrote it
  always_comb begin
    ovh_next = ovh_reg;
    if (psel && penable && pwrite && paddr == TCM_GLOBAL_CTRL_OFS) begin
      ovh_next = pwdata[0];
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ovh_reg <= 1'b0;
    end else begin
      ovh_reg <= ovh_next;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  zero_wait_a: assert property (psel && penable |-> pready && !pslverr)
    else $error("bus access not answered at once");
  idle_data_a: assert property (!rd_acc |-> prdata == 32'h0)
    else $error("read data outside a read access");
  ctrl_read_a: assert property (rd_acc && paddr == TCM_GLOBAL_CTRL_OFS |-> prdata == {31'h0, ovh_reg})
    else $error("overhead bit readback wrong");
  unmapped_a: assert property (rd_acc && paddr >= 12'h020 |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  answer_time_a: assert property (req_valid && req_entry < ENTRIES |-> ##2 res_valid)
    else $error("lookup answer late or missing");
  answer_cause_a: assert property (res_valid |-> $past(req_valid, 2))
    else $error("answer without request");
  color_hold_a: assert property ($past(rst_n) && !res_valid |-> $stable(res_color))
    else $error("color changed without answer");
  clr_reads_zero_a: assert property (rd_acc && paddr == TCM_ENTRY_CFG2_OFS |-> !prdata[27])
    else $error("clear control reads back set");

  // Main scenarios reached
  cover property (res_valid && res_color == TCM_RED);
  cover property (res_valid && res_color == TCM_YELLOW);
  cover property (psel && penable && pwrite && paddr == TCM_GLOBAL_CTRL_OFS && pwdata[0]);
endmodule

bind tcm_meter tcm_meter_monitor #(.ENTRIES(ENTRIES), .TICK_CYCLES(TICK_CYCLES)) mon_u (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .req_valid(req_valid), .req_entry(req_entry), .req_len(req_len), .req_color(req_color),
  .res_valid(res_valid), .res_color(res_color));
`default_nettype wire
